// ### logic/rail_seq_map.svh
// Register offsets, reset values and timing constants of the rail sequencer.
`ifndef RAIL_SEQ_MAP_SVH
`define RAIL_SEQ_MAP_SVH

`define BOOST_CTRL_OFS 8'h08
`define FIRST_BUCK_DELAY_OFS 8'h09
`define SECOND_BUCK_DELAY_OFS 8'h0A
`define BOOST_DELAY_OFS 8'h0B

`define BOOST_CTRL_RST 8'h08
`define DELAY_RST 8'h00
`define UNMAPPED_READ 8'h00

`define GATE_NONE 2'h0
`define GATE_PIN_ONE 2'h1
`define GATE_PIN_TWO 2'h2
`define GATE_PIN_THREE 2'h3

`define RAIL_FIRST_BUCK 0
`define RAIL_SECOND_BUCK 1
`define RAIL_BOOST 2
`define RAIL_COUNT 3

`define STEP_TIME_US 500
`define CLK_FREQ_MHZ 100
`define DELAY_CODE_ZERO 4'h0
`define STEPS_ZERO 5'h00
`define STEPS_ONE 5'h01

`endif

// ### logic/rail_seq_pkg.sv
// Types shared by the rail sequencer.
package rail_seq_pkg;

    typedef struct packed {
        logic [1:0] voltage_select;
        logic reserved_hi;
        logic reserved_lo;
        logic discharge_enable;
        logic [1:0] pin_gating_select;
        logic boost_on_bit;
    } boost_ctrl_t;

    typedef struct packed {
        logic [3:0] off_code;
        logic [3:0] on_code;
    } delay_fields_t;

    typedef enum logic [1:0] {
        RAIL_OFF = 2'b00,
        RAIL_WAIT_ON = 2'b01,
        RAIL_ON = 2'b11,
        RAIL_WAIT_OFF = 2'b10
    } rail_state_t;

endpackage

// ### logic/rail_enable_delay_sequencer.sv
// Boost control register and start-up/shut-down delay sequencing of three rails.
`include "rail_seq_map.svh"

// Behaviour
// - Boost voltage from bits 7:6, four levels.
// - Discharge resistor on while boost off, if enabled.
// - Gating select ANDs boost bit with chosen pin.
// - Boost runs when gated control is asserted.
// - Start-up delay after rising control edge.
// - Shut-down delay after falling control edge.
// - Step 0.5 ms, or 1 ms when doubled.
// - Defaults loaded from programmable memory after reset, except the discharge enable bit and reserved bits 5:4.
module rail_enable_delay_sequencer
    import rail_seq_pkg::*;
#(
    parameter int STEP_CYCLES = `STEP_TIME_US * `CLK_FREQ_MHZ
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port of the serial interface
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Programmed defaults
    input wire logic [7:0] otp_boost_ctrl,
    input wire logic [7:0] otp_first_buck_delay,
    input wire logic [7:0] otp_second_buck_delay,
    input wire logic [7:0] otp_boost_delay,
    // Configuration and rail control
    input wire logic delay_step_double,
    input wire logic first_buck_ctrl,
    input wire logic second_buck_ctrl,
    // Enable pins
    input wire logic enable_input_one,
    input wire logic enable_input_two,
    input wire logic enable_input_three,
    // Rail outputs
    output logic [2:0] rail_on,
    output logic [1:0] boost_voltage_select,
    output logic boost_discharge_on
);

    boost_ctrl_t boost_ctrl_reg, boost_ctrl_next;
    delay_fields_t delay_reg [`RAIL_COUNT];
    delay_fields_t delay_next [`RAIL_COUNT];
    logic load_pending_reg, load_pending_next;
    logic [7:0] reg_rdata_reg, reg_rdata_next;
    logic reg_rvalid_reg, reg_rvalid_next;
    logic [2:0] pin_meta_reg, pin_sync_reg;
    logic boost_gate;
    logic boost_level;
    logic [2:0] rail_ctrl;
    rail_state_t state_reg [`RAIL_COUNT];
    rail_state_t state_next [`RAIL_COUNT];
    logic [31:0] pre_reg [`RAIL_COUNT];
    logic [31:0] pre_next [`RAIL_COUNT];
    logic [4:0] steps_reg [`RAIL_COUNT];
    logic [4:0] steps_next [`RAIL_COUNT];
    logic discharge_reg, discharge_next;
    logic rail_on_next [`RAIL_COUNT];
    boost_ctrl_t otp_ctrl;

    assign otp_ctrl = otp_boost_ctrl;

    // Pins are asynchronous to core_clk.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {enable_input_three, enable_input_two, enable_input_one};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Register file; the programmed defaults are taken on the first edge after release,
    // since an asynchronous reset may only load constants.
    always_comb begin
        boost_ctrl_next = boost_ctrl_reg;
        delay_next = delay_reg;
        load_pending_next = 1'b0;
        reg_rdata_next = reg_rdata_reg;
        reg_rvalid_next = reg_read;
        if (load_pending_reg) begin
            boost_ctrl_next.voltage_select = otp_ctrl.voltage_select;
            boost_ctrl_next.pin_gating_select = otp_ctrl.pin_gating_select;
            boost_ctrl_next.boost_on_bit = otp_ctrl.boost_on_bit;
            delay_next[`RAIL_FIRST_BUCK] = otp_first_buck_delay;
            delay_next[`RAIL_SECOND_BUCK] = otp_second_buck_delay;
            delay_next[`RAIL_BOOST] = otp_boost_delay;
        end else if (reg_write) begin
            if (reg_addr == `BOOST_CTRL_OFS) begin
                boost_ctrl_next = reg_wdata;
            end else if (reg_addr == `FIRST_BUCK_DELAY_OFS) begin
                delay_next[`RAIL_FIRST_BUCK] = reg_wdata;
            end else if (reg_addr == `SECOND_BUCK_DELAY_OFS) begin
                delay_next[`RAIL_SECOND_BUCK] = reg_wdata;
            end else if (reg_addr == `BOOST_DELAY_OFS) begin
                delay_next[`RAIL_BOOST] = reg_wdata;
            end
        end
        if (reg_read) begin
            if (reg_addr == `BOOST_CTRL_OFS) begin
                reg_rdata_next = boost_ctrl_reg;
            end else if (reg_addr == `FIRST_BUCK_DELAY_OFS) begin
                reg_rdata_next = delay_reg[`RAIL_FIRST_BUCK];
            end else if (reg_addr == `SECOND_BUCK_DELAY_OFS) begin
                reg_rdata_next = delay_reg[`RAIL_SECOND_BUCK];
            end else if (reg_addr == `BOOST_DELAY_OFS) begin
                reg_rdata_next = delay_reg[`RAIL_BOOST];
            end else begin
                reg_rdata_next = `UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            boost_ctrl_reg <= `BOOST_CTRL_RST;
            for (int i = 0; i < `RAIL_COUNT; i++) begin
                delay_reg[i] <= `DELAY_RST;
            end
            load_pending_reg <= 1'b1;
            reg_rdata_reg <= `UNMAPPED_READ;
            reg_rvalid_reg <= 1'b0;
        end else begin
            boost_ctrl_reg <= boost_ctrl_next;
            delay_reg <= delay_next;
            load_pending_reg <= load_pending_next;
            reg_rdata_reg <= reg_rdata_next;
            reg_rvalid_reg <= reg_rvalid_next;
        end
    end

    // Boost control signal after optional pin gating.
    always_comb begin
        case (boost_ctrl_reg.pin_gating_select)
            `GATE_PIN_ONE: boost_gate = pin_sync_reg[0];
            `GATE_PIN_TWO: boost_gate = pin_sync_reg[1];
            `GATE_PIN_THREE: boost_gate = pin_sync_reg[2];
            default: boost_gate = 1'b1;
        endcase
        boost_level = boost_ctrl_reg.boost_on_bit & boost_gate;
        rail_ctrl = {boost_level, second_buck_ctrl, first_buck_ctrl};
    end

    // Per-rail delay timers.
    generate
        for (genvar r = 0; r < `RAIL_COUNT; r++) begin : g_rail
            logic [4:0] on_steps, off_steps;
            logic step_done;
            always_comb begin
                // Doubling the step is done by counting twice as many half steps.
                on_steps = delay_step_double ? {delay_reg[r].on_code, 1'b0}
                                             : {1'b0, delay_reg[r].on_code};
                off_steps = delay_step_double ? {delay_reg[r].off_code, 1'b0}
                                              : {1'b0, delay_reg[r].off_code};
                step_done = (pre_reg[r] == 32'(STEP_CYCLES - 1));
                state_next[r] = state_reg[r];
                pre_next[r] = pre_reg[r];
                steps_next[r] = steps_reg[r];
                case (state_reg[r])
                    RAIL_OFF: begin
                        if (rail_ctrl[r]) begin
                            pre_next[r] = 32'h0;
                            steps_next[r] = on_steps;
                            state_next[r] = (on_steps == `STEPS_ZERO) ? RAIL_ON
                                                                      : RAIL_WAIT_ON;
                        end
                    end
                    RAIL_WAIT_ON: begin
                        if (!rail_ctrl[r]) begin
                            state_next[r] = RAIL_OFF;
                        end else if (step_done) begin
                            pre_next[r] = 32'h0;
                            steps_next[r] = steps_reg[r] - `STEPS_ONE;
                            if (steps_reg[r] == `STEPS_ONE) begin
                                state_next[r] = RAIL_ON;
                            end
                        end else begin
                            pre_next[r] = pre_reg[r] + 32'h1;
                        end
                    end
                    RAIL_ON: begin
                        if (!rail_ctrl[r]) begin
                            pre_next[r] = 32'h0;
                            steps_next[r] = off_steps;
                            state_next[r] = (off_steps == `STEPS_ZERO) ? RAIL_OFF
                                                                       : RAIL_WAIT_OFF;
                        end
                    end
                    default: begin
                        if (rail_ctrl[r]) begin
                            state_next[r] = RAIL_ON;
                        end else if (step_done) begin
                            pre_next[r] = 32'h0;
                            steps_next[r] = steps_reg[r] - `STEPS_ONE;
                            if (steps_reg[r] == `STEPS_ONE) begin
                                state_next[r] = RAIL_OFF;
                            end
                        end else begin
                            pre_next[r] = pre_reg[r] + 32'h1;
                        end
                    end
                endcase
                rail_on_next[r] = state_next[r][1];
            end
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    state_reg[r] <= RAIL_OFF;
                    pre_reg[r] <= 32'h0;
                    steps_reg[r] <= `STEPS_ZERO;
                end else begin
                    state_reg[r] <= state_next[r];
                    pre_reg[r] <= pre_next[r];
                    steps_reg[r] <= steps_next[r];
                end
            end
        end
    endgenerate

    // Discharge is registered from the next rail state so it never overlaps a running boost.
    always_comb begin
        discharge_next = boost_ctrl_reg.discharge_enable & ~rail_on_next[`RAIL_BOOST];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            discharge_reg <= 1'b1;
        end else begin
            discharge_reg <= discharge_next;
        end
    end

    assign rail_on = {state_reg[2][1], state_reg[1][1], state_reg[0][1]};
    assign boost_voltage_select = boost_ctrl_reg.voltage_select;
    assign boost_discharge_on = discharge_reg;
    assign reg_rdata = reg_rdata_reg;
    assign reg_rvalid = reg_rvalid_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_voltage_write;
        !load_pending_reg && reg_write && reg_addr == `BOOST_CTRL_OFS
            |=> boost_voltage_select == $past(reg_wdata[7:6]);
    endproperty
    a_voltage_write: assert property (p_voltage_write) else $error("voltage select not written");

    property p_discharge;
        ##1 boost_discharge_on == ($past(boost_ctrl_reg.discharge_enable) && !rail_on[2]);
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge wrong for boost state");

    property p_gating;
        boost_ctrl_reg.pin_gating_select == `GATE_PIN_TWO && !pin_sync_reg[1] |-> !boost_level;
    endproperty
    a_gating: assert property (p_gating) else $error("pin gating ignored");

    property p_ungated;
        boost_ctrl_reg.pin_gating_select == `GATE_NONE
            |-> boost_level == boost_ctrl_reg.boost_on_bit;
    endproperty
    a_ungated: assert property (p_ungated) else $error("boost bit alone not in control");

    property p_zero_on;
        state_reg[0] == RAIL_OFF && first_buck_ctrl && delay_reg[0].on_code == `DELAY_CODE_ZERO
            |=> rail_on[0];
    endproperty
    a_zero_on: assert property (p_zero_on) else $error("zero start-up delay not immediate");

    property p_zero_off;
        state_reg[0] == RAIL_ON && !first_buck_ctrl && delay_reg[0].off_code == `DELAY_CODE_ZERO
            |=> !rail_on[0];
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("zero shut-down delay not immediate");

    property p_last_step;
        state_reg[1] == RAIL_WAIT_ON && second_buck_ctrl && steps_reg[1] == `STEPS_ONE &&
            pre_reg[1] == 32'(STEP_CYCLES - 1) |=> rail_on[1] && state_reg[1] == RAIL_ON;
    endproperty
    a_last_step: assert property (p_last_step) else $error("rail late after last step");

    property p_wait_holds;
        state_reg[1] == RAIL_WAIT_ON && second_buck_ctrl && steps_reg[1] > `STEPS_ONE
            |=> !rail_on[1];
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("rail started early");

    // The release edge itself still takes the reset branch, so only a load edge out of reset counts.
    property p_otp_load;
        resetn && load_pending_reg |=> delay_reg[2] == $past(otp_boost_delay) &&
            boost_ctrl_reg.boost_on_bit == $past(otp_ctrl.boost_on_bit);
    endproperty
    a_otp_load: assert property (p_otp_load) else $error("defaults not loaded");

    property p_abandon;
        state_reg[0] == RAIL_WAIT_OFF && first_buck_ctrl |=> state_reg[0] == RAIL_ON;
    endproperty
    a_abandon: assert property (p_abandon) else $error("pending shut-down not abandoned");

    c_boost_on: cover property (state_reg[2] == RAIL_WAIT_ON ##1 state_reg[2] == RAIL_ON);
    c_buck_off: cover property (state_reg[0] == RAIL_WAIT_OFF ##1 state_reg[0] == RAIL_OFF);
    c_abandon: cover property (state_reg[0] == RAIL_WAIT_ON ##1 state_reg[0] == RAIL_OFF);

endmodule

// ### test/host_bus_model.sv
// Host side model: register byte port and the three enable pins.
module host_bus_model (
    // Clock
    input wire logic core_clk,
    // Register port
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Enable pins
    output logic enable_input_one,
    output logic enable_input_two,
    output logic enable_input_three
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        enable_input_one = 1'b0;
        enable_input_two = 1'b0;
        enable_input_three = 1'b0;
    end

    // Bits 5:4 of the boost control byte are always sent as 0 and 1.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= (a == 8'h08) ? {d[7:6], 2'b01, d[3:0]} : d;
        @(posedge core_clk);
        reg_write <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // The answer is taken at the edge after the one that accepts the read.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        @(posedge core_clk);
        d = reg_rdata;
        v = reg_rvalid;
    endtask

    task automatic set_pins(input logic [2:0] p);
        @(posedge core_clk);
        enable_input_one <= p[0];
        enable_input_two <= p[1];
        enable_input_three <= p[2];
    endtask
endmodule

// ### test/tb_rail_enable_delay_sequencer.sv
// Self-checking bench of the boost control and rail delay sequencer.
module tb_rail_enable_delay_sequencer;
    import rail_seq_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int STEP = 4;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_write, reg_read, reg_rvalid, boost_discharge_on;
    logic en_one, en_two, en_three;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic delay_step_double = 1'b0;
    logic first_buck_ctrl = 1'b0;
    logic second_buck_ctrl = 1'b0;
    logic [7:0] otp_boost_ctrl = 8'hC5;
    logic [7:0] otp_first_buck_delay = 8'h21;
    logic [7:0] otp_second_buck_delay = 8'h43;
    logic [7:0] otp_boost_delay = 8'h12;
    logic [2:0] rail_on;
    logic [1:0] boost_voltage_select;
    int n_fail = 0;
    int check_count = 0;
    int codes[3] = '{0, 1, 15};

    always #5 core_clk = ~core_clk;

    host_bus_model i_host (.core_clk(core_clk), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .enable_input_one(en_one), .enable_input_two(en_two),
        .enable_input_three(en_three));

    rail_enable_delay_sequencer #(.STEP_CYCLES(STEP)) i_dut (.core_clk(core_clk),
        .resetn(resetn), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .otp_boost_ctrl(otp_boost_ctrl), .otp_first_buck_delay(otp_first_buck_delay),
        .otp_second_buck_delay(otp_second_buck_delay), .otp_boost_delay(otp_boost_delay),
        .delay_step_double(delay_step_double), .first_buck_ctrl(first_buck_ctrl),
        .second_buck_ctrl(second_buck_ctrl), .enable_input_one(en_one),
        .enable_input_two(en_two), .enable_input_three(en_three), .rail_on(rail_on),
        .boost_voltage_select(boost_voltage_select), .boost_discharge_on(boost_discharge_on));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        i_host.read_reg(a, d, v);
        check(32'(v), 32'h1);
        check(32'(d), 32'(e));
    endtask

    // Counts edges from the control change until the rail follows it.
    task automatic drive_ctrl(input int r, input logic lvl, input int exp_n);
        int n;
        @(posedge core_clk);
        if (r == 0) first_buck_ctrl <= lvl;
        else second_buck_ctrl <= lvl;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (rail_on[r] !== lvl && n < 300);
        check(32'(n), 32'(exp_n));
    endtask

    task automatic wait_edges(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    // Holds the first buck control away from its level for ten edges, then counts
    // the edges at which the rail leaves that level.
    task automatic pulse_ctrl(input logic lvl);
        int bad;
        bad = 0;
        @(posedge core_clk);
        first_buck_ctrl <= ~lvl;
        repeat (10) @(posedge core_clk);
        first_buck_ctrl <= lvl;
        for (int k = 0; k < 16 * STEP + 10; k++) begin
            wait_edges(1);
            if (rail_on[0] !== lvl) bad++;
        end
        check(32'(bad), 32'h0);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        check(32'(rail_on), 32'h0);
        check(32'(boost_discharge_on), 32'h1);
        @(posedge core_clk);
        resetn <= 1'b1;
        wait_edges(1);
        check(32'(boost_voltage_select), 32'h3);
        expect_reg(8'h08, 8'hCD);
        expect_reg(8'h09, 8'h21);
        expect_reg(8'h0A, 8'h43);
        expect_reg(8'h0B, 8'h12);
        expect_reg(8'h0C, 8'h00);
        i_host.write_reg(8'h0B, 8'h00);
        for (int g = 0; g < 4; g++) begin
            i_host.set_pins(g == 0 ? 3'b000 : 3'b111 ^ (3'b001 << (g - 1)));
            i_host.write_reg(8'h08, {g[1:0], 2'b01, 1'b1, g[1:0], 1'b1});
            wait_edges(8);
            check(32'(boost_voltage_select), 32'(g));
            check(32'(rail_on[2]), 32'(g == 0));
            check(32'(boost_discharge_on), 32'(g != 0));
            expect_reg(8'h08, {g[1:0], 2'b01, 1'b1, g[1:0], 1'b1});
            i_host.set_pins(3'b111);
            wait_edges(8);
            check(32'(rail_on[2]), 32'h1);
            i_host.write_reg(8'h08, {g[1:0], 2'b01, 1'b0, g[1:0], 1'b0});
            wait_edges(8);
            check(32'(rail_on[2]), 32'h0);
            check(32'(boost_discharge_on), 32'h0);
        end
        for (int d = 0; d < 2; d++) begin
            foreach (codes[i]) begin
                @(posedge core_clk);
                delay_step_double <= d[0];
                i_host.write_reg(8'h09, {codes[i][3:0], codes[i][3:0]});
                drive_ctrl(0, 1'b1, 1 + codes[i] * (d + 1) * STEP);
                drive_ctrl(0, 1'b0, 1 + codes[i] * (d + 1) * STEP);
            end
        end
        @(posedge core_clk);
        delay_step_double <= 1'b0;
        i_host.write_reg(8'h0A, 8'h53);
        drive_ctrl(1, 1'b1, 1 + 3 * STEP);
        drive_ctrl(1, 1'b0, 1 + 5 * STEP);
        // Short pulses inside a pending start-up or shut-down delay never reach the rail.
        i_host.write_reg(8'h09, 8'h0F);
        pulse_ctrl(1'b0);
        i_host.write_reg(8'h09, 8'hF0);
        drive_ctrl(0, 1'b1, 1);
        pulse_ctrl(1'b1);
        // Boost start-up by register; discharge drops at the edge the rail rises.
        i_host.write_reg(8'h0B, 8'h02);
        i_host.write_reg(8'h08, 8'h19);
        wait_edges(2 * STEP);
        check(32'(rail_on[2]), 32'h0);
        check(32'(boost_discharge_on), 32'h1);
        wait_edges(1);
        check(32'(rail_on[2]), 32'h1);
        check(32'(boost_discharge_on), 32'h0);
        // A second reset drops the rails and loads the programmed defaults again.
        @(posedge core_clk);
        resetn <= 1'b0;
        wait_edges(2);
        check(32'(rail_on), 32'h0);
        check(32'(boost_discharge_on), 32'h1);
        @(posedge core_clk);
        resetn <= 1'b1;
        wait_edges(1);
        check(32'(boost_voltage_select), 32'h3);
        expect_reg(8'h0B, 8'h12);
        give_verdict();
    end
endmodule
